// File: clock_mode_and_reset_control.sv
/*
  Clock mode and reset controller: picks 6 or 12 oscillator periods per
  machine cycle, derives per-peripheral tick enables, qualifies the reset
  input, forces port reset, latches the program strap and makes the
  address latch strobe. Registers sit on a 32-bit APB slave.
  Assumes all inputs are synchronous to ref_clk except reset_in, which
  also sets the port reset asynchronously.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
// Functional notes
// - reset input held high two machine cycles resets the device
// - ports forced to reset state asynchronously once reset input is high
// - program strap captured when reset releases, later changes ignored
// - address latch strobe pulses twice per machine cycle normally
// - one strobe pulse of the cycle omitted during external data access
// - strobe disable bit set: strobe only during external data move
// - programmed fuse forces 6-clock mode over the register bit
// - fuse erased: register bit 1 gives 6 clocks, 0 gives 12
// - in 6-clock mode each peripheral picks divide by 6 or 12
// - divider bits 6..1: watchdog, counter array, serial, timers 2,1,0
// - in 12-clock mode every peripheral ticks at divide by 12
// - serial divider applies only to fixed-rate modes 0 and 2
module clock_mode_and_reset_control (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device pins and fuse
  input  wire logic        reset_in,
  input  wire logic        external_program_strap,
  input  wire logic        fuse_six_clock_force,
  // core status inputs
  input  wire logic        xdata_access,
  input  wire logic        external_data_move_instruction,
  input  wire logic        serial_fixed_rate_mode,
  input  wire logic        serial_baud_overflow,
  // reset outputs
  output logic             device_reset,
  output logic             port_reset,
  output logic             strap_latched,
  // strobe and tick outputs
  output logic             address_latch_strobe,
  output logic             core_tick,
  output logic             watchdog_tick,
  output logic             counter_array_tick,
  output logic             serial_tick,
  output logic             timer_two_tick,
  output logic             timer_one_tick,
  output logic             timer_zero_tick
);

  localparam int NP = clock_mode_pkg::NUM_PERIPH;

  typedef enum logic [2:0] {
    RST_HELD = 3'b001,
    RST_ARM  = 3'b010,
    RST_RUN  = 3'b100
  } reset_state_t;

  osc_phase_if phase ();

  osc_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .phase   (phase)
  );

  // registers
  logic [7:0]   clock_divider_control_reg;
  logic [7:0]   aux_control_reg;
  logic         pready_reg;
  logic [31:0]  prdata_reg;
  logic         pslverr_reg;
  reset_state_t rst_state_reg;
  reset_state_t rst_state_next;
  logic [1:0]   hold_cnt_reg;
  logic         strap_reg;
  logic         port_reset_reg;
  logic         device_reset_reg;
  logic         ale_reg;
  logic         core_tick_reg;
  logic [NP-1:0] periph_tick_reg;
  logic         serial_tick_reg;

  // decoded state
  logic         six_clock_mode;
  logic         slot_a;
  logic         slot_b;
  logic         ale_next;
  logic         apb_access;
  logic         apb_write;
  logic         addr_hit;
  logic [31:0]  read_word;
  logic [NP-1:0] periph_tick_next;
  logic [NP-1:0] periph_divider;

  // programmed fuse wins over whatever software wrote to bit 0
  assign six_clock_mode = fuse_six_clock_force |
    clock_divider_control_reg[clock_mode_pkg::CORE_HALF_CYCLE_SELECT_BIT];

  assign periph_divider = clock_divider_control_reg[
    clock_mode_pkg::PERIPH_DIVIDER_LSB +: NP];

  // machine cycle split into two strobe slots; slot_b ends the cycle
  assign slot_a = six_clock_mode ?
                  (phase.tick_third & ~phase.tick_sixth) :
                  (phase.tick_sixth & ~phase.tick_twelfth);
  assign slot_b = six_clock_mode ? phase.tick_sixth : phase.tick_twelfth;

  // apb decode; writes to the status word are dropped without an error
  assign apb_access = psel & penable & pready_reg;
  assign apb_write  = apb_access & pwrite;
  assign addr_hit   = (paddr == clock_mode_pkg::ADDR_CLOCK_DIVIDER_CONTROL) ||
                      (paddr == clock_mode_pkg::ADDR_AUX_CONTROL) ||
                      (paddr == clock_mode_pkg::ADDR_CLOCK_STATUS);

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      clock_mode_pkg::ADDR_CLOCK_DIVIDER_CONTROL: begin
        // reserved top bit never stored, reads zero
        read_word[7:0] = clock_divider_control_reg;
      end
      clock_mode_pkg::ADDR_AUX_CONTROL: begin
        read_word[7:0] = aux_control_reg;
      end
      clock_mode_pkg::ADDR_CLOCK_STATUS: begin
        read_word[clock_mode_pkg::STAT_SIX_CLOCK_BIT]    = six_clock_mode;
        read_word[clock_mode_pkg::STAT_STRAP_BIT]        = strap_reg;
        read_word[clock_mode_pkg::STAT_DEVICE_RESET_BIT] =
          (rst_state_reg == RST_HELD);
        read_word[clock_mode_pkg::STAT_FUSE_BIT]         = fuse_six_clock_force;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : read_word;
        pslverr_reg <= ~addr_hit;
      end else begin
        prdata_reg  <= 32'h0000_0000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_divider_control_reg <= clock_mode_pkg::CLOCK_DIVIDER_RESET;
    end else if (apb_write &&
                 paddr == clock_mode_pkg::ADDR_CLOCK_DIVIDER_CONTROL) begin
      clock_divider_control_reg <= pwdata[7:0] &
                                   clock_mode_pkg::CLOCK_DIVIDER_WMASK;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aux_control_reg <= clock_mode_pkg::AUX_CONTROL_RESET;
    end else if (apb_write && paddr == clock_mode_pkg::ADDR_AUX_CONTROL) begin
      aux_control_reg <= 8'h00;
      aux_control_reg[clock_mode_pkg::ALE_DISABLE_BIT] <=
        pwdata[clock_mode_pkg::ALE_DISABLE_BIT];
    end
  end

  // reset qualification: count machine-cycle ends while the pin is high;
  // the first end may close a partial cycle, so two ends still mean the
  // pin saw at least one full cycle plus the part before it
  always_comb begin
    rst_state_next = rst_state_reg;
    unique case (rst_state_reg)
      RST_HELD: begin
        if (!reset_in) begin
          rst_state_next = RST_RUN;
        end
      end
      RST_ARM: begin
        if (!reset_in) begin
          rst_state_next = RST_RUN;
        end else if (slot_b &&
                     hold_cnt_reg == clock_mode_pkg::RESET_HOLD_CYCLES - 2'h1)
        begin
          rst_state_next = RST_HELD;
        end
      end
      RST_RUN: begin
        if (reset_in) begin
          rst_state_next = RST_ARM;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_state_reg <= RST_HELD;
    end else begin
      rst_state_reg <= rst_state_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_reg <= 2'h0;
    end else if (rst_state_reg != RST_ARM) begin
      hold_cnt_reg <= 2'h0;
    end else if (slot_b) begin
      hold_cnt_reg <= hold_cnt_reg + 2'h1;
    end
  end

  // strap sampled only on the cycle the device leaves reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_reg <= 1'b0;
    end else if (rst_state_reg == RST_HELD && rst_state_next == RST_RUN) begin
      strap_reg <= external_program_strap;
    end
  end

  // port reset sets straight from the pin with no clock edge needed;
  // it clears only once the qualified reset has been released
  always_ff @(posedge ref_clk or negedge nrst or posedge reset_in) begin
    if (!nrst) begin
      port_reset_reg <= 1'b1;
    end else if (reset_in) begin
      port_reset_reg <= 1'b1;
    end else begin
      port_reset_reg <= (rst_state_reg == RST_HELD);
    end
  end

  // core reset follows the qualified state only, so a pin pulse that ends
  // before the second machine-cycle end resets the ports but never the core; taken
  // from the next state so it lines up with the state flop itself
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      device_reset_reg <= 1'b1;
    end else begin
      device_reset_reg <= (rst_state_next == RST_HELD);
    end
  end

  // strobe: two slots per machine cycle, first slot dropped on an
  // external data access, all gated off by the disable bit unless an
  // external data move is running
  assign ale_next =
    (rst_state_next != RST_HELD) &&
    ((slot_a && !xdata_access) ||
     slot_b) &&
    (!aux_control_reg[clock_mode_pkg::ALE_DISABLE_BIT] ||
     external_data_move_instruction);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ale_reg <= 1'b0;
    end else begin
      ale_reg <= ale_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_tick_reg <= 1'b0;
    end else begin
      core_tick_reg <= slot_b;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_periph
      // divider bit only honoured in 6-clock mode
      assign periph_tick_next[gi] =
        (six_clock_mode && !periph_divider[gi]) ?
        phase.tick_sixth :
        phase.tick_twelfth;

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          periph_tick_reg[gi] <= 1'b0;
        end else begin
          periph_tick_reg[gi] <= periph_tick_next[gi];
        end
      end
    end
  endgenerate

  // variable-rate serial modes are paced by a timer overflow instead
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serial_tick_reg <= 1'b0;
    end else if (serial_fixed_rate_mode) begin
      serial_tick_reg <=
        periph_tick_next[clock_mode_pkg::PERIPH_SERIAL];
    end else begin
      serial_tick_reg <= serial_baud_overflow;
    end
  end

  // outputs; port reset follows the pin at once, device reset only after two machine-cycle ends
  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign device_reset         = device_reset_reg;
  assign port_reset           = port_reset_reg;
  assign strap_latched        = strap_reg;
  assign address_latch_strobe = ale_reg;
  assign core_tick            = core_tick_reg;
  assign watchdog_tick        =
    periph_tick_reg[clock_mode_pkg::PERIPH_WATCHDOG];
  assign counter_array_tick   =
    periph_tick_reg[clock_mode_pkg::PERIPH_COUNTER_ARRAY];
  assign serial_tick          = serial_tick_reg;
  assign timer_two_tick       =
    periph_tick_reg[clock_mode_pkg::PERIPH_TIMER_TWO];
  assign timer_one_tick       =
    periph_tick_reg[clock_mode_pkg::PERIPH_TIMER_ONE];
  assign timer_zero_tick      =
    periph_tick_reg[clock_mode_pkg::PERIPH_TIMER_ZERO];

endmodule : clock_mode_and_reset_control

// File: clock_mode_and_reset_control_assertions.sv
/*
  Port-level checks on the clock mode and reset controller.
  Assumes it is bound to the controller and sees only its ports.
*/
module clock_mode_and_reset_control_assertions (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // pins and core status
  input wire logic        reset_in,
  input wire logic        fuse_six_clock_force,
  input wire logic        xdata_access,
  input wire logic        external_data_move_instruction,
  input wire logic        serial_fixed_rate_mode,
  // watched outputs
  input wire logic        device_reset,
  input wire logic        port_reset,
  input wire logic        strap_latched,
  input wire logic        address_latch_strobe,
  input wire logic        core_tick,
  input wire logic        timer_zero_tick,
  input wire logic        timer_one_tick,
  input wire logic        timer_two_tick,
  input wire logic        serial_tick,
  input wire logic        counter_array_tick,
  input wire logic        watchdog_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic [6:0]  div_reg;
  logic        aux_reg;
  logic [12:0] watch_reg;
  logic [4:0]  calm_reg;
  logic [4:0]  rin_reg;
  logic [2:0]  sn_reg;
  wire  [6:0]  ticks = {watchdog_tick, counter_array_tick, serial_tick,
                        timer_two_tick, timer_one_tick, timer_zero_tick,
                        core_tick};
  wire         six = fuse_six_clock_force | div_reg[0];
  wire         strobe_on = (!aux_reg | external_data_move_instruction)
                           & !device_reset;
  wire         calm = calm_reg >= 5'h1A;
  wire         wr = psel & penable & pready & pwrite;
  wire  [12:0] watch = {div_reg, aux_reg, fuse_six_clock_force,
                        xdata_access, external_data_move_instruction,
                        serial_fixed_rate_mode, device_reset};

  // shadows follow completed writes only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 7'h00;
      aux_reg <= 1'b0;
    end else if (wr && paddr == 8'h00) begin
      div_reg <= pwdata[6:0];
    end else if (wr && paddr == 8'h04) begin
      aux_reg <= pwdata[0];
    end
  end

  // periods are judged only once the controls have settled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      watch_reg <= 13'h0000;
      calm_reg  <= 5'h00;
      rin_reg   <= 5'h00;
      sn_reg    <= 3'h0;
    end else begin
      watch_reg <= watch;
      calm_reg  <= (watch != watch_reg) ? 5'h00 :
                   (calm_reg == 5'h1F) ? calm_reg : calm_reg + 5'h01;
      rin_reg   <= !reset_in ? 5'h00 :
                   (rin_reg == 5'h1F) ? rin_reg : rin_reg + 5'h01;
      sn_reg    <= core_tick ? 3'h0 : sn_reg + 3'(address_latch_strobe);
    end
  end

  for (genvar i = 0; i < 7; i++) begin : g_tick
    logic [3:0] gap_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
        gap_reg <= 4'h0;
      else
        gap_reg <= ticks[i] ? 4'h0 : gap_reg + 4'h1;
    end
    AST_TICK_PERIOD: assert property (
      ticks[i] && calm && (i != 4 || serial_fixed_rate_mode) |->
      gap_reg == ((six && (i == 0 || !div_reg[i])) ? 4'h5 : 4'hB))
      else $error("tick period wrong");
  end

  AST_STROBE_PER_CYCLE: assert property (
    core_tick && calm && strobe_on |->
    sn_reg + 3'(address_latch_strobe) == (xdata_access ? 3'h1 : 3'h2))
    else $error("strobe count per machine cycle wrong");
  AST_STROBE_OFF: assert property (
    calm && !strobe_on |-> !address_latch_strobe)
    else $error("strobe not suppressed");
  AST_TICK_SINGLE: assert property (
    $rose(core_tick) |=> $fell(core_tick))
    else $error("core tick longer than one cycle");
  AST_PORT_ASYNC: assert property (
    reset_in |-> port_reset)
    else $error("port reset missing");
  AST_STRAP_HOLD: assert property (
    !device_reset ##1 !device_reset |-> $stable(strap_latched))
    else $error("strap changed outside reset");
  AST_RESET_HOLD: assert property (
    rin_reg >= 5'h1B |-> device_reset)
    else $error("long reset pulse ignored");
  AST_RESET_EXIT: assert property (
    $fell(device_reset) |-> !$past(reset_in))
    else $error("reset left while pin high");

  COV_SIX: cover property (core_tick && six);
  COV_RESET: cover property ($rose(device_reset));
  COV_SKIP: cover property (core_tick && calm && xdata_access && strobe_on);
endmodule : clock_mode_and_reset_control_assertions

bind clock_mode_and_reset_control clock_mode_and_reset_control_assertions
  i_assertions (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .reset_in, .fuse_six_clock_force, .xdata_access,
  .external_data_move_instruction, .serial_fixed_rate_mode, .device_reset,
  .port_reset, .strap_latched, .address_latch_strobe, .core_tick,
  .timer_zero_tick, .timer_one_tick, .timer_two_tick, .serial_tick,
  .counter_array_tick, .watchdog_tick);

// File: clock_mode_and_reset_control_tb_top.sv
/*
  Self-checking bench for the clock mode and reset controller.
  Assumes the checker binds itself and the partner drives reset_in.
*/
module clock_mode_and_reset_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_DIV = clock_mode_pkg::ADDR_CLOCK_DIVIDER_CONTROL;
  localparam logic [7:0] A_AUX = clock_mode_pkg::ADDR_AUX_CONTROL;
  localparam logic [7:0] A_STAT = clock_mode_pkg::ADDR_CLOCK_STATUS;

  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        reset_in, external_program_strap, fuse_six_clock_force;
  logic        xdata_access, external_data_move_instruction;
  logic        serial_fixed_rate_mode, serial_baud_overflow;
  logic        device_reset, port_reset, strap_latched;
  logic        address_latch_strobe;
  logic [6:0]  ticks;
  int          latch_count, err_count, tests_run, cycles;

  clock_mode_and_reset_control i_dut (.ref_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_in,
    .external_program_strap, .fuse_six_clock_force, .xdata_access,
    .external_data_move_instruction, .serial_fixed_rate_mode,
    .serial_baud_overflow, .device_reset, .port_reset, .strap_latched,
    .address_latch_strobe, .core_tick(ticks[0]),
    .timer_zero_tick(ticks[1]), .timer_one_tick(ticks[2]),
    .timer_two_tick(ticks[3]), .serial_tick(ticks[4]),
    .counter_array_tick(ticks[5]), .watchdog_tick(ticks[6]));

  reset_circuit_model i_partner (.ref_clk, .reset_in,
    .address_latch_strobe, .latch_count);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // whole run needs about 1350 cycles
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp,
                           input logic exp_err, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp, what);
    chk({31'h0, e}, {31'h0, exp_err}, what);
  endtask : reg_check

  // edges between two consecutive pulses of one tick
  task automatic check_period(input int i, input logic [31:0] exp);
    int n;
    int p;
    n = 0;
    p = 1;
    while (ticks[i] !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    while (ticks[i] !== 1'b1 && p < 40) begin
      @(posedge ref_clk);
      p++;
    end
    chk(32'(p), exp, "tick period");
  endtask : check_period

  initial begin
    logic [7:0] mv [5];
    logic       fz [5];
    logic       six;
    int         c0;
    mv = '{8'h00, 8'h01, 8'h55, 8'h2B, 8'h54};
    fz = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {fuse_six_clock_force, xdata_access, serial_baud_overflow} = '0;
    external_data_move_instruction = 1'b0;
    external_program_strap = 1'b1;
    serial_fixed_rate_mode = 1'b1;
    {err_count, tests_run, cycles} = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, strap_latched}, 32'h1, "strap at start");
    reg_check(A_DIV, 32'h0, 1'b0, "divider reset");
    reg_check(A_AUX, 32'h0, 1'b0, "aux reset");
    reg_check(8'h0C, 32'h0, 1'b1, "unmapped");
    for (int m = 0; m < 5; m++) begin
      fuse_six_clock_force <= fz[m];
      reg_write(A_DIV, mv[m] | 8'h80);
      six = fz[m] | mv[m][0];
      reg_check(A_DIV, {24'h0, mv[m]}, 1'b0, "divider");
      reg_check(A_STAT, {28'h0, fz[m], 2'b01, six}, 1'b0, "status");
      repeat (30) @(posedge ref_clk);
      for (int i = 0; i < 7; i++)
        check_period(i, (six && (i == 0 || !mv[m][i])) ? 6 : 12);
    end
    fuse_six_clock_force <= 1'b0;
    reg_write(A_DIV, 8'h00);
    for (int k = 0; k < 4; k++) begin
      xdata_access <= k == 1;
      external_data_move_instruction <= k == 3;
      reg_write(A_AUX, {7'h00, k >= 2});
      repeat (30) @(posedge ref_clk);
      c0 = latch_count;
      repeat (120) @(posedge ref_clk);
      chk(32'(latch_count - c0), k == 1 ? 10 : k == 2 ? 0 : 20, "strobes");
    end
    external_data_move_instruction <= 1'b0;
    reg_write(A_AUX, 8'h00);
    serial_fixed_rate_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    c0 = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      serial_baud_overflow <= k % 10 == 0;
      if (ticks[4] === 1'b1)
        c0++;
    end
    chk(32'(c0), 32'h4, "serial overflow ticks");
    serial_fixed_rate_mode <= 1'b1;
    fork
      i_partner.drive_reset(30);
      begin
        #1;
        chk({31'h0, port_reset}, 32'h1, "port reset");
        repeat (29) @(posedge ref_clk);
        chk({31'h0, device_reset}, 32'h1, "device reset");
        external_program_strap <= 1'b0;
      end
    join
    repeat (40) @(posedge ref_clk);
    chk({31'h0, device_reset}, 32'h0, "reset released");
    chk({31'h0, strap_latched}, 32'h0, "strap relatched");
    external_program_strap <= 1'b1;
    repeat (10) @(posedge ref_clk);
    i_partner.drive_reset(3);
    chk({31'h0, device_reset}, 32'h0, "short pulse core");
    repeat (10) @(posedge ref_clk);
    chk({31'h0, strap_latched}, 32'h0, "strap held");
    chk({31'h0, port_reset}, 32'h0, "short pulse");
    print_verdict();
  end
endmodule : clock_mode_and_reset_control_tb_top

// File: clock_mode_pkg.sv
/*
  Constants shared by the clock mode and reset controller and its
  oscillator prescaler: register offsets, field positions, reset values,
  prescaler phases and the reset hold length.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package clock_mode_pkg;

  // register map
  localparam logic [7:0] ADDR_CLOCK_DIVIDER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_AUX_CONTROL           = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_STATUS          = 8'h08;

  // clock_divider_control fields
  localparam int         CORE_HALF_CYCLE_SELECT_BIT = 0;
  localparam int         PERIPH_DIVIDER_LSB         = 1;
  localparam int         NUM_PERIPH                 = 6;
  localparam logic [7:0] CLOCK_DIVIDER_WMASK        = 8'h7F;
  localparam logic [7:0] CLOCK_DIVIDER_RESET        = 8'h00;

  // peripheral index, equal to bit position minus one
  localparam int PERIPH_TIMER_ZERO    = 0;
  localparam int PERIPH_TIMER_ONE     = 1;
  localparam int PERIPH_TIMER_TWO     = 2;
  localparam int PERIPH_SERIAL        = 3;
  localparam int PERIPH_COUNTER_ARRAY = 4;
  localparam int PERIPH_WATCHDOG      = 5;

  // aux_control fields
  localparam int         ALE_DISABLE_BIT   = 0;
  localparam logic [7:0] AUX_CONTROL_RESET = 8'h00;

  // clock_status fields
  localparam int STAT_SIX_CLOCK_BIT    = 0;
  localparam int STAT_STRAP_BIT        = 1;
  localparam int STAT_DEVICE_RESET_BIT = 2;
  localparam int STAT_FUSE_BIT         = 3;

  // prescaler: one count per oscillator period, twelve per slow tick
  localparam logic [3:0] PHASE_LAST  = 4'hB;
  localparam logic [3:0] PHASE_ZERO  = 4'h0;
  localparam logic [3:0] PHASE_THIRD_A = 4'h2;
  localparam logic [3:0] PHASE_SIXTH_A = 4'h5;
  localparam logic [3:0] PHASE_THIRD_B = 4'h8;

  // reset input must stay high this many machine cycles
  localparam logic [1:0] RESET_HOLD_CYCLES = 2'h2;

endpackage : clock_mode_pkg

// File: osc_phase_if.sv
/*
  Phase ticks from the oscillator prescaler to the clock mode logic.
  Assumes both ends run on the same oscillator clock.
*/
interface osc_phase_if;
  logic tick_third;
  logic tick_sixth;
  logic tick_twelfth;

  modport src (
    output tick_third,
    output tick_sixth,
    output tick_twelfth
  );

  modport snk (
    input tick_third,
    input tick_sixth,
    input tick_twelfth
  );
endinterface : osc_phase_if

// File: osc_prescaler.sv
/*
  Free-running divide-by-twelve prescaler on the oscillator clock.
  Gives one-period ticks every 3, 6 and 12 oscillator periods, all
  aligned so that the slower ticks coincide with the faster ones.
  Assumes an asynchronous active-low reset.
*/
module osc_prescaler (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  // phase ticks
  osc_phase_if.src    phase
);

  logic [3:0] phase_reg;
  logic [3:0] phase_next;

  assign phase_next = (phase_reg == clock_mode_pkg::PHASE_LAST) ?
                      clock_mode_pkg::PHASE_ZERO :
                      phase_reg + 4'h1;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= clock_mode_pkg::PHASE_ZERO;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ticks registered so consumers see clean single-cycle pulses
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase.tick_third   <= 1'b0;
      phase.tick_sixth   <= 1'b0;
      phase.tick_twelfth <= 1'b0;
    end else begin
      phase.tick_third   <= (phase_next == clock_mode_pkg::PHASE_THIRD_A) ||
                            (phase_next == clock_mode_pkg::PHASE_SIXTH_A) ||
                            (phase_next == clock_mode_pkg::PHASE_THIRD_B) ||
                            (phase_next == clock_mode_pkg::PHASE_LAST);
      phase.tick_sixth   <= (phase_next == clock_mode_pkg::PHASE_SIXTH_A) ||
                            (phase_next == clock_mode_pkg::PHASE_LAST);
      phase.tick_twelfth <= (phase_next == clock_mode_pkg::PHASE_LAST);
    end
  end

endmodule : osc_prescaler

// File: reset_circuit_model.sv
/*
  External reset circuit and address latch facing the controller.
  Assumes drive_reset is called just after a clock edge.
*/
module reset_circuit_model (
  // clock
  input  wire logic ref_clk,
  // reset pin, pulled low when idle
  output logic      reset_in,
  // strobe and latch activity
  input  wire logic address_latch_strobe,
  output int        latch_count
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reset_in = 1'b0;
    latch_count = 0;
  end

  // each strobe latches one address byte
  always @(posedge ref_clk) begin
    if (address_latch_strobe === 1'b1)
      latch_count <= latch_count + 1;
  end

  task automatic drive_reset(input int cycles);
    reset_in <= 1'b1;
    repeat (cycles) @(posedge ref_clk);
    reset_in <= 1'b0;
  endtask : drive_reset
endmodule : reset_circuit_model
